// [rtl/pieim_pkg.sv]
// Package: register map, field positions and reset values for the block
package pieim_pkg;
  localparam int          ADDR_W          = 8;     // Byte address width
  // Register byte addresses
  localparam logic [7:0]  ADDR_ENABLE     = 8'h8C; // peripheral_irq_enable
  localparam logic [7:0]  ADDR_FLAGS      = 8'h0C; // peripheral_irq_flags
  localparam logic [7:0]  ADDR_CORE_CTRL  = 8'h8B; // core_irq_control
  localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h40; // Sticky event status
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h44; // Event status mask
  // Field positions
  localparam int          BIT_CONV        = 6;
  localparam int          BIT_SERIAL      = 3;
  localparam int          BIT_CAPCMP      = 2;
  localparam int          BIT_PERIOD      = 1;
  localparam int          BIT_WIDE_OVF    = 0;
  localparam int          BIT_GLOBAL      = 7;     // In core_irq_control
  localparam int          BIT_PERIPH      = 6;     // In core_irq_control
  localparam int          BIT_REQ         = 0;     // In status and mask
  // Implemented bits of enable/flag, core control and status/mask registers; reset byte and responses
  localparam logic [7:0]  IMPL_MASK       = 8'h4F;
  localparam logic [7:0]  CORE_MASK       = 8'hC0;
  localparam logic [7:0]  REQ_MASK        = 8'h01;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage : pieim_pkg

// [rtl/pieim_evt_if.sv]
// Interface: peripheral event pulses and flag state between modules
interface pieim_evt_if;
  logic [7:0] events;   // One-cycle event pulses, flag layout
  logic [7:0] clr;      // Software clear pulses, flag layout
  logic [7:0] flags;    // Current flag state
  modport owner (input events, input clr, output flags);
  modport user  (output events, output clr, input flags);
endinterface : pieim_evt_if

// [rtl/pieim_flags.sv]
// Flag register: hardware sets, software clears, set wins on collision
module pieim_flags (
  input  wire logic   i_clock,
  input  wire logic   i_rst_n,
  pieim_evt_if.owner  evt
);
  logic [7:0] flags_w;   // Flag bits gathered from the per-bit flops

  // One generate per flag bit; unimplemented positions stay zero.
  // Each bit owns its flop, so no variable has two kinds of driver.
  genvar g;
  for (g = 0; g < 8; g++) begin : g_flag
    if (pieim_pkg::IMPL_MASK[g]) begin : g_impl
      logic bit_ff;      // This flag
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          bit_ff <= 1'b0;
        end else if (evt.events[g]) begin
          // Set regardless of any enable; wins over a clear
          bit_ff <= 1'b1; // R6 R8
        end else if (evt.clr[g]) begin
          bit_ff <= 1'b0; // R8
        end
      end
      assign flags_w[g] = bit_ff;
    end else begin : g_none
      assign flags_w[g] = 1'b0;
    end
  end

  assign evt.flags = flags_w;
endmodule : pieim_flags

// [rtl/pieim_top.sv]
// Top: peripheral interrupt enable register, gating and AXI4-Lite slave
// Operation
// R1 - Bits 7, 5, 4 read zero, ignore writes
// R2 - Bit 6 enables conversion-complete interrupt
// R3 - Bits 3..0 enable serial, capcmp, period, overflow
// R4 - Enable bits read/write, zero after reset
// R5 - Peripheral enable gates all peripheral requests
// R6 - Flags set regardless of any enable
// R7 - Software clears flag before enabling it
// R8 - Flags match enable positions, software clears
// R9 - Request when flag, enable, both globals set
//
// The implementer's own choice: the AXI4-Lite slave port.
module pieim_top (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // Peripheral event pulses, same clock
  input  wire logic        i_conv_done,
  input  wire logic        i_serial_evt,
  input  wire logic        i_capcmp_evt,
  input  wire logic        i_period_match,
  input  wire logic        i_wide_timer_ovf,
  // AXI4-Lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Interrupt outputs
  output logic             o_periph_irq_req,
  output logic             o_irq
);
  // Reset synchroniser: async assert, two-flop release
  logic rst_s1_ff;  // First stage
  logic rst_n_ff;   // Released reset for the design
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  logic [7:0] enable_ff;     // peripheral_irq_enable
  logic [7:0] core_ff;       // core_irq_control global bits
  logic [7:0] stat_ff;       // Sticky status
  logic [7:0] mask_ff;       // Status mask
  logic       req_ff;        // Registered request
  logic       irq_ff;        // Registered interrupt line

  pieim_evt_if evt ();

  // Event pulses gathered at flag positions
  always_comb begin
    evt.events = pieim_pkg::RESET_BYTE;
    evt.events[pieim_pkg::BIT_CONV]     = i_conv_done;
    evt.events[pieim_pkg::BIT_SERIAL]   = i_serial_evt;
    evt.events[pieim_pkg::BIT_CAPCMP]   = i_capcmp_evt;
    evt.events[pieim_pkg::BIT_PERIOD]   = i_period_match;
    evt.events[pieim_pkg::BIT_WIDE_OVF] = i_wide_timer_ovf;
  end

  pieim_flags u_flags (
    .i_clock (i_clock),
    .i_rst_n (rst_n_ff),
    .evt     (evt)
  );

  // Write channel capture: address and data taken in either order
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        have_aw_ff;
  logic        have_w_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        do_write;
  logic        hit_w;
  logic [7:0]  wbyte;
  logic        wr_en;       // Write that touches byte lane 0

  assign do_write = have_aw_ff && have_w_ff && !bvalid_ff;
  // Lane 0 off leaves every register as it was; a zero byte instead
  // would wipe the enables and clear every pending flag
  assign wr_en    = do_write && wstrb_ff[0];
  assign wbyte    = wdata_ff[7:0];

  // Address decode of the pending write
  always_comb begin
    case (waddr_ff)
      pieim_pkg::ADDR_ENABLE,
      pieim_pkg::ADDR_FLAGS,
      pieim_pkg::ADDR_CORE_CTRL,
      pieim_pkg::ADDR_IRQ_STAT,
      pieim_pkg::ADDR_IRQ_MASK: hit_w = 1'b1;
      default:                  hit_w = 1'b0;
    endcase
  end

  // Accept address and data; hold each until the write is done
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      waddr_ff   <= pieim_pkg::RESET_BYTE;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else if (do_write) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
    end else begin
      if (i_awvalid && !have_aw_ff) begin
        have_aw_ff <= 1'b1;
        waddr_ff   <= i_awaddr;
      end
      if (i_wvalid && !have_w_ff) begin
        have_w_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wstrb_ff  <= i_wstrb;
      end
    end
  end

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= pieim_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= hit_w ? pieim_pkg::RESP_OKAY : pieim_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Enable register: only implemented bits store, others stay zero
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      enable_ff <= pieim_pkg::RESET_BYTE; // R4
    end else if (wr_en && waddr_ff == pieim_pkg::ADDR_ENABLE) begin
      enable_ff <= wbyte & pieim_pkg::IMPL_MASK; // R1 R2 R3
    end
  end

  // Global enables of the core control register
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      core_ff <= pieim_pkg::RESET_BYTE;
    end else if (wr_en && waddr_ff == pieim_pkg::ADDR_CORE_CTRL) begin
      core_ff <= wbyte & pieim_pkg::CORE_MASK;
    end
  end

  // Flag clear: writing zero to a set flag clears it; ones leave it.
  // Software cannot set a flag, so a stale one must be cleared first.
  always_comb begin
    evt.clr = pieim_pkg::RESET_BYTE;
    if (wr_en && waddr_ff == pieim_pkg::ADDR_FLAGS) begin
      evt.clr = ~wbyte & pieim_pkg::IMPL_MASK; // R8 R7
    end
  end

  // Request gating: flag and enable, peripheral and global enables
  logic req_nxt;
  assign req_nxt = (|(evt.flags & enable_ff))
                 && core_ff[pieim_pkg::BIT_PERIPH]   // R5
                 && core_ff[pieim_pkg::BIT_GLOBAL];  // R9

  // Status and mask; request rising edge sets sticky status
  logic req_rise;
  assign req_rise = req_nxt && !req_ff;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stat_ff <= pieim_pkg::RESET_BYTE;
    end else if (req_rise) begin
      // Set wins over a simultaneous write-one clear
      stat_ff <= stat_ff | pieim_pkg::REQ_MASK;
    end else if (wr_en && waddr_ff == pieim_pkg::ADDR_IRQ_STAT) begin
      stat_ff <= stat_ff & ~(wbyte & pieim_pkg::REQ_MASK);
    end
  end

  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mask_ff <= pieim_pkg::RESET_BYTE;
    end else if (wr_en && waddr_ff == pieim_pkg::ADDR_IRQ_MASK) begin
      mask_ff <= wbyte & pieim_pkg::REQ_MASK;
    end
  end

  // Registered outputs of request and masked interrupt
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      req_ff <= req_nxt; // R9
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // Read channel: one read at a time; data follow the address handshake
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rbyte;
  logic        hit_r;
  always_comb begin
    hit_r = 1'b1;
    case (i_araddr)
      pieim_pkg::ADDR_ENABLE:    rbyte = enable_ff; // R1
      pieim_pkg::ADDR_FLAGS:     rbyte = evt.flags;
      pieim_pkg::ADDR_CORE_CTRL: rbyte = core_ff;
      pieim_pkg::ADDR_IRQ_STAT:  rbyte = stat_ff;
      pieim_pkg::ADDR_IRQ_MASK:  rbyte = mask_ff;
      default: begin
        rbyte = pieim_pkg::RESET_BYTE;
        hit_r = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= pieim_pkg::RESP_OKAY;
    end else if (arready_ff && i_arvalid) begin
      // Answer only once the address is taken, never alongside arready
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rbyte};
      rresp_ff  <= hit_r ? pieim_pkg::RESP_OKAY : pieim_pkg::RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Ready flags registered so every output comes from a flop
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  always_ff @(posedge i_clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      awready_ff <= i_awvalid && !have_aw_ff && !awready_ff;
      wready_ff  <= i_wvalid && !have_w_ff && !wready_ff;
      arready_ff <= i_arvalid && !rvalid_ff && !arready_ff;
    end
  end

  assign o_awready        = awready_ff;
  assign o_wready         = wready_ff;
  assign o_bvalid         = bvalid_ff;
  assign o_bresp          = bresp_ff;
  assign o_arready        = arready_ff;
  assign o_rvalid         = rvalid_ff;
  assign o_rdata          = rdata_ff;
  assign o_rresp          = rresp_ff;
  assign o_periph_irq_req = req_ff;
  assign o_irq            = irq_ff;
endmodule : pieim_top

// [tb/pieim_evt_src.sv]
// Event source model: one-cycle peripheral event pulses
module pieim_evt_src (
  input  wire logic       i_clock,
  input  wire logic [4:0] i_kick,  // Bench request: conv,serial,capcmp,period,ovf
  output logic      [4:0] o_evt    // Event pulses into the block
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered, so an event lands a cycle after the request like a real one
  always_ff @(posedge i_clock) begin
    o_evt <= i_kick;
  end
endmodule // pieim_evt_src

// [tb/pieim_checker.sv]
// Checker: port-level assertions for the interrupt enable block
module pieim_checker (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_awvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_awready,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [7:0]  i_araddr,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_periph_irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  logic [1:0] core_ff; // Shadow of the two global enables
  // Shadow moves at the write edge, as the real register does; it
  // assumes address and data are offered together
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) core_ff <= 2'h0;
    else if (o_awready && i_wstrb[0]
             && i_awaddr == pieim_pkg::ADDR_CORE_CTRL) core_ff <= i_wdata[7:6];
  end
  sequence s_wr_req; i_awvalid && i_wvalid && !o_bvalid; endsequence
  sequence s_bresp; ##[1:6] o_bvalid; endsequence
  property p_enable_rsvd; o_arready && i_araddr == pieim_pkg::ADDR_ENABLE
    |=> (o_rdata[7:0] & ~pieim_pkg::IMPL_MASK) == 8'h00; endproperty
  a_enable_rsvd: assert property (p_enable_rsvd)
    else $error("reserved enable bits read nonzero");
  property p_flag_rsvd; o_arready && i_araddr == pieim_pkg::ADDR_FLAGS
    |=> (o_rdata[7:0] & ~pieim_pkg::IMPL_MASK) == 8'h00; endproperty
  a_flag_rsvd: assert property (p_flag_rsvd)
    else $error("reserved flag bits read nonzero");
  property p_upper; o_rvalid |-> o_rdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read data nonzero");
  property p_req_quiet; $rose(i_rstn) |-> !o_periph_irq_req [*3]; endproperty
  a_req_quiet: assert property (p_req_quiet)
    else $error("request right after reset");
  // The request is registered, so it answers the enables one cycle late
  property p_gate; o_periph_irq_req |-> $past(core_ff) == 2'h3; endproperty
  a_gate: assert property (p_gate)
    else $error("request without both global enables");
  property p_rd_order; o_arready |-> !o_rvalid; endproperty
  a_rd_order: assert property (p_rd_order)
    else $error("read data offered before address taken");
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read response dropped or changed");
  property p_wr_resp; s_wr_req |-> s_bresp; endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
endmodule // pieim_checker
bind pieim_top pieim_checker i_pieim_checker (.i_clock, .i_rstn, .i_awaddr,
  .i_awvalid, .i_wdata, .i_wstrb, .i_wvalid, .o_awready, .o_bvalid, .i_bready,
  .i_araddr, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_periph_irq_req);

// [tb/testbench.sv]
// Testbench: enable register, gating and status interrupt over AXI4-Lite
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_periph_irq_req, o_irq;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rdat;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic [4:0]  kick, evt;
  int          n_mismatch, tests_run;
  pieim_top i_pieim_top (.i_clock, .i_rstn, .i_conv_done(evt[4]),
    .i_serial_evt(evt[3]), .i_capcmp_evt(evt[2]), .i_period_match(evt[1]),
    .i_wide_timer_ovf(evt[0]), .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .o_periph_irq_req, .o_irq);
  pieim_evt_src i_pieim_evt_src (.i_clock, .i_kick(kick), .o_evt(evt));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, a);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Step n edges, then look at outputs where they have settled
  task automatic wait_neg(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  // Handshakes are sampled at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge i_clock);
    {i_awaddr, i_wdata} <= {a, 24'h000000, d};
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    // Only the watchdog ends a wait that never sees the answer
    while (!b) begin
      @(negedge i_clock);
      {aw, w, b, resp} = {o_awready, o_wready, o_bvalid, o_bresp};
      @(posedge i_clock);
      if (aw) i_awvalid <= 1'h0;
      if (w) i_wvalid <= 1'h0;
      if (b) i_bready <= 1'h0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge i_clock);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
    while (!r) begin
      @(negedge i_clock);
      {ar, r, rdat, resp} = {o_arready, o_rvalid, o_rdata, o_rresp};
      @(posedge i_clock);
      if (ar) i_arvalid <= 1'h0;
      if (r) i_rready <= 1'h0;
    end
  endtask
  task automatic rc(input logic [7:0] a, e, input string nm);
    rd(a);
    chk(nm, {24'h000000, e}, rdat);
    chk("rresp", pieim_pkg::RESP_OKAY, resp);
  endtask
  // Event lands a cycle late, flag a cycle later, request one more
  task automatic fire(input logic [4:0] v);
    @(posedge i_clock);
    kick <= v;
    @(posedge i_clock);
    kick <= 5'h00;
    wait_neg(4);
  endtask
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    cyc(5000);
    n_mismatch++;
    end_sim();
  end
  initial begin
    int p;
    {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, kick} = {48'h0, 4'hF, 5'h00};
    cyc(16);
    i_rstn <= 1'h1;
    cyc(3);
    rc(pieim_pkg::ADDR_ENABLE, 8'h00, "enable reset");
    rc(pieim_pkg::ADDR_FLAGS, 8'h00, "flags reset");
    wr(pieim_pkg::ADDR_ENABLE, 8'hFF);
    rc(pieim_pkg::ADDR_ENABLE, 8'h4F, "enable all");
    i_wstrb <= 4'h0;
    wr(pieim_pkg::ADDR_ENABLE, 8'h00);
    i_wstrb <= 4'hF;
    rc(pieim_pkg::ADDR_ENABLE, 8'h4F, "enable lane off");
    wr(pieim_pkg::ADDR_ENABLE, 8'hB0);
    rc(pieim_pkg::ADDR_ENABLE, 8'h00, "enable reserved");
    fire(5'h1F);
    rc(pieim_pkg::ADDR_FLAGS, 8'h4F, "flags disabled");
    wr(pieim_pkg::ADDR_FLAGS, 8'h00);
    chk("bresp ok", pieim_pkg::RESP_OKAY, resp);
    rc(pieim_pkg::ADDR_FLAGS, 8'h00, "flags cleared");
    wr(pieim_pkg::ADDR_CORE_CTRL, 8'hC0);
    for (int i = 0; i < 5; i++) begin
      p = (i == 4) ? 6 : i;
      wr(pieim_pkg::ADDR_ENABLE, 8'(1 << p));
      fire(5'(1 << ((i + 1) % 5)));
      chk("req other", 1'h0, o_periph_irq_req);
      wr(pieim_pkg::ADDR_FLAGS, 8'h00);
      fire(5'(1 << i));
      chk("req own", 1'h1, o_periph_irq_req);
      wr(pieim_pkg::ADDR_FLAGS, 8'h00);
      wait_neg(3);
      chk("req cleared", 1'h0, o_periph_irq_req);
    end
    // Flag and enable match, so only the globals hold the request back
    fire(5'h01);
    wr(pieim_pkg::ADDR_CORE_CTRL, 8'h40);
    wr(pieim_pkg::ADDR_ENABLE, 8'h01);
    wait_neg(3);
    chk("req no global", 1'h0, o_periph_irq_req);
    wr(pieim_pkg::ADDR_CORE_CTRL, 8'h80);
    wait_neg(3);
    chk("req no periph", 1'h0, o_periph_irq_req);
    wr(pieim_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(pieim_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(pieim_pkg::ADDR_CORE_CTRL, 8'hC0);
    wait_neg(3);
    chk("req both", 1'h1, o_periph_irq_req);
    chk("irq masked", 1'h0, o_irq);
    rc(pieim_pkg::ADDR_IRQ_STAT, 8'h01, "status");
    wr(pieim_pkg::ADDR_IRQ_MASK, 8'h01);
    wait_neg(3);
    chk("irq", 1'h1, o_irq);
    wr(pieim_pkg::ADDR_IRQ_STAT, 8'h01);
    wait_neg(3);
    chk("irq cleared", 1'h0, o_irq);
    wr(8'h10, 8'hFF);
    chk("bresp", pieim_pkg::RESP_SLVERR, resp);
    rd(8'h10);
    chk("rresp unmapped", pieim_pkg::RESP_SLVERR, resp);
    chk("rdata unmapped", 32'h0, rdat);
    end_sim();
  end
endmodule // testbench
